// ==== cmd_fifo.sv ====
`timescale 1ns/1ns

// Single-clock FIFO with valid/ready on both sides
module cmd_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Pointers wrap naturally, so depth must be a power of two
   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gBadDepth
         $error("cmd_fifo: DEPTH must be a power of two, at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wrPtr_q;
   logic [PW-1:0]    rdPtr_q;
   logic [PW:0]      count_q;
   logic             push;
   logic             pop;

   assign inReady  = (count_q != DEPTH[PW:0]);
   assign outValid = (count_q != '0);
   assign outData  = mem_q[rdPtr_q];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   // Storage, no reset needed on the data words
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wrPtr_q] <= inData;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) wrPtr_q <= wrPtr_q + 1'h1;
         if (pop)  rdPtr_q <= rdPtr_q + 1'h1;
         count_q <= count_q + {{PW{1'h0}}, push} - {{PW{1'h0}}, pop};
      end
   end

endmodule

// ==== eeprom_host.sv ====
`timescale 1ns/1ns
// ----
// Host side of the serial link
// ----
module eeprom_host (
   input  wire logic sysClk,
   output logic      serialClockLine,
   output logic      selectLine,
   output logic      serialInLine,
   input  wire logic serialOut,
   input  wire logic serialOutEn
);
   logic [15:0] rdWord;
   logic        rdDummy;
   logic        rdEnable;
   logic        rdTail;

   // Link clock rests low outside frames
   initial begin
      serialClockLine = 1'b0;
      selectLine      = 1'b0;
      serialInLine    = 1'b0;
   end

   // One 6 ns period per bit, data set half a period before the edge
   task automatic sendBit(input logic b);
      serialInLine = b;
      #3 serialClockLine = 1'b1;
      #3 serialClockLine = 1'b0;
   endtask

   // Unused line toggles so a stale value is never mistaken for data
   task automatic idleClocks(input int n);
      repeat (n) sendBit(~serialInLine);
   endtask

   // Start bit, opcode, address, then the data word if one follows
   task automatic sendCmd(input logic [3:0] op, input logic [3:0] addr,
                          input logic [15:0] data, input logic hasData);
      selectLine = 1'b1;
      #3 sendBit(1'b1);
      for (int i = 3; i >= 0; i--) sendBit(op[i]);
      for (int i = 3; i >= 0; i--) sendBit(addr[i]);
      if (hasData) begin
         for (int i = 15; i >= 0; i--) sendBit(data[i]);
      end
      serialInLine = ~serialInLine;
   endtask

   // Select stays up so the command crosses before it drops
   task automatic endFrame;
      repeat (10) @(negedge sysClk);
      selectLine = 1'b0;
      repeat (4) @(negedge sysClk);
   endtask

   // Select-low span times programming; then high for a while
   task automatic progCycle(input int lowCycles);
      repeat (10) @(negedge sysClk);
      selectLine = 1'b0;
      repeat (lowCycles) @(negedge sysClk);
      selectLine = 1'b1;
      repeat (10) @(negedge sysClk);
      selectLine = 1'b0;
      repeat (4) @(negedge sysClk);
   endtask

   // Samples each output bit half a period after its edge
   task automatic readWord(input logic [3:0] op, input logic [3:0] addr);
      sendCmd(op, addr, 16'h0000, 1'b0);
      rdDummy  = serialOut;
      rdEnable = serialOutEn;
      for (int i = 15; i >= 0; i--) begin
         sendBit(~serialInLine);
         rdWord[i] = serialOut;
      end
      idleClocks(2);
      rdTail = serialOutEn;
      endFrame();
   endtask
endmodule

// ==== eeprom_pkg.sv ====
package eeprom_pkg;

   // Serial frame tracker, runs on the link clock
   typedef enum logic [2:0] {
      LK_LEAD = 3'b000,
      LK_HDR  = 3'b001,
      LK_DATA = 3'b010,
      LK_READ = 3'b011,
      LK_DONE = 3'b100
   } link_state_e;

   // Programming executor, runs on the system clock
   typedef enum logic [1:0] {
      EX_IDLE = 2'b00,
      EX_ARM  = 2'b01,
      EX_PROG = 2'b10
   } exec_state_e;

endpackage

// ==== eeprom_regs.svh ====
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

// ------------------------------------------------------------
// Array geometry and frame layout
// ------------------------------------------------------------
`define WORD_BITS      16
`define ADDR_BITS      4
`define OP_BITS        4
`define ARRAY_WORDS    16
`define CMD_BITS       24
`define CMD_OP_MSB     23
`define CMD_OP_LSB     20
`define CMD_ADDR_MSB   19
`define CMD_ADDR_LSB   16
`define CMD_DATA_MSB   15
`define HDR_LAST       5'h07
`define DATA_LAST      5'h0F
`define READ_LAST      5'h0F
`define FIFO_DEPTH     8

// ------------------------------------------------------------
// Opcodes and reset values
// ------------------------------------------------------------
`define OPHI_READ      2'h2
`define OPHI_WRITE     2'h1
`define OPHI_ERASE     2'h3
`define OPHI_SPECIAL   2'h0
`define OP_PROG_EN     4'h3
`define OP_PROG_DIS    4'h0
`define OP_BULK_ERASE  4'h2
`define OP_BULK_WRITE  4'h1
`define ERASED_WORD    16'hFFFF
`define PROG_EN_RESET  1'h0

`endif

// ==== serial_eeprom_program_cmds.sv ====
`timescale 1ns/1ns
`include "eeprom_regs.svh"

module serial_eeprom_program_cmds
   import eeprom_pkg::*;
#(
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic serialClockLine,
   input  wire logic selectLine,
   input  wire logic serialInLine,
   output logic      serialOut,
   output logic      serialOutEn,
   output logic      progVoltageOn,
   output logic      progEnabled
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic                 linkRstMeta_q;
   logic                 linkRst_q;
   logic                 frameRst;
   link_state_e          lkState_q;
   logic [4:0]           bitCnt_q;
   logic [6:0]           hdr_q;
   logic [7:0]           hdrFull;
   logic [`OP_BITS-1:0]  op_q;
   logic [`ADDR_BITS-1:0] addr_q;
   logic [`WORD_BITS-1:0] data_q;
   logic [`WORD_BITS-1:0] rdShift_q;
   logic [`ADDR_BITS-1:0] rdAddr_q;
   logic [`WORD_BITS-1:0] readWord;
   logic                 hdrDone;
   logic                 dataDone;
   logic                 hdrIsRead;
   logic                 hdrHasData;
   logic                 emitNow;
   logic [`CMD_BITS-1:0] emitWord;
   logic [`CMD_BITS-1:0] cmdWord_q;
   logic                 reqTgl_q;
   logic                 ackSync;
   logic                 csSync;
   logic                 reqSync;
   logic                 reqSeen_q;
   logic                 ackTgl_q;
   logic                 pendValid_q;
   logic [`CMD_BITS-1:0] pendWord_q;
   logic                 fifoInReady;
   logic                 fifoOutValid;
   logic [`CMD_BITS-1:0] fifoOutData;
   logic                 exPop;
   exec_state_e          exState_q;
   logic [`CMD_BITS-1:0] exWord_q;
   logic [`OP_BITS-1:0]  popOp;
   logic                 popIsProg;
   logic                 progStart;
   logic [`OP_BITS-1:0]  exOp;
   logic [`ADDR_BITS-1:0] exAddr;
   logic [`WORD_BITS-1:0] exData;
   logic [`WORD_BITS-1:0] mem_q [`ARRAY_WORDS];

   // ------------------------------------------------------------
   // Link clock domain
   // ------------------------------------------------------------

   // Reset release aligned to the link clock
   always_ff @(posedge serialClockLine or posedge sys_rst) begin
      if (sys_rst) begin
         linkRstMeta_q <= 1'h1;
         linkRst_q     <= 1'h1;
      end else begin
         linkRstMeta_q <= 1'h0;
         linkRst_q     <= linkRstMeta_q;
      end
   end

   // The frame ends with select, not with a clock edge that may never come
   assign frameRst = linkRst_q | ~selectLine;

   // Header decode on the edge that takes the last address bit
   assign hdrFull    = {hdr_q, serialInLine};
   assign hdrDone    = (lkState_q == LK_HDR) && (bitCnt_q == `HDR_LAST);
   assign dataDone   = (lkState_q == LK_DATA) && (bitCnt_q == `DATA_LAST);
   assign hdrIsRead  = (hdrFull[7:6] == `OPHI_READ);
   assign hdrHasData = (hdrFull[7:6] == `OPHI_WRITE) ||
                       (hdrFull[7:4] == `OP_BULK_WRITE);

   // Frame sequencing: start bit, opcode, address, then payload
   always_ff @(posedge serialClockLine or posedge frameRst) begin
      if (frameRst) begin
         lkState_q <= LK_LEAD;
         bitCnt_q  <= 5'h00;
      end else begin
         case (lkState_q)
            LK_LEAD: begin
               // Zeros ahead of the start bit are idle line
               if (serialInLine) begin
                  lkState_q <= LK_HDR;
                  bitCnt_q  <= 5'h00;
               end
            end
            LK_HDR: begin
               if (hdrDone) begin
                  bitCnt_q <= 5'h00;
                  if (hdrIsRead) begin
                     lkState_q <= LK_READ;
                  end else if (hdrHasData) begin
                     lkState_q <= LK_DATA;
                  end else begin
                     lkState_q <= LK_DONE;
                  end
               end else begin
                  bitCnt_q <= bitCnt_q + 5'h01;
               end
            end
            LK_DATA: begin
               if (dataDone) begin
                  lkState_q <= LK_DONE;
               end
               bitCnt_q <= bitCnt_q + 5'h01;
            end
            LK_READ: begin
               if (bitCnt_q == `READ_LAST) begin
                  lkState_q <= LK_DONE;
               end
               bitCnt_q <= bitCnt_q + 5'h01;
            end
            LK_DONE: begin
               // Extra clocks are ignored until select drops
               lkState_q <= LK_DONE;
            end
            default: begin
               lkState_q <= LK_LEAD;
            end
         endcase
      end
   end

   // Header and data shifters, most significant bit first
   always_ff @(posedge serialClockLine or posedge frameRst) begin
      if (frameRst) begin
         hdr_q  <= 7'h00;
         op_q   <= 4'h0;
         addr_q <= 4'h0;
         data_q <= 16'h0000;
      end else begin
         if (lkState_q == LK_HDR) begin
            hdr_q <= hdrFull[6:0];
         end
         if (hdrDone) begin
            op_q   <= hdrFull[7:4];
            addr_q <= hdrFull[3:0];
         end
         if (lkState_q == LK_DATA) begin
            data_q <= {data_q[`WORD_BITS-2:0], serialInLine};
         end
      end
   end

   // Array word for reads; only changes while select is low, so stable in a read
   assign readWord = mem_q[rdAddr_q];

   // Read output: dummy zero, then sixteen data bits on rising edges
   always_ff @(posedge serialClockLine or posedge frameRst) begin
      if (frameRst) begin
         serialOut   <= 1'h0;
         serialOutEn <= 1'h0;
         rdAddr_q    <= 4'h0;
         rdShift_q   <= 16'h0000;
      end else begin
         if (hdrDone && hdrIsRead) begin
            serialOut   <= 1'h0;
            serialOutEn <= 1'h1;
            rdAddr_q    <= hdrFull[3:0];
         end else if (lkState_q == LK_READ) begin
            if (bitCnt_q == 5'h00) begin
               serialOut <= readWord[`WORD_BITS-1];
               rdShift_q <= {readWord[`WORD_BITS-2:0], 1'h0};
            end else begin
               serialOut <= rdShift_q[`WORD_BITS-1];
               rdShift_q <= {rdShift_q[`WORD_BITS-2:0], 1'h0};
            end
         end else begin
            serialOut   <= 1'h0;
            serialOutEn <= 1'h0;
         end
      end
   end

   // Every command except a read goes to the system side
   assign emitNow  = (hdrDone && !hdrIsRead && !hdrHasData) || dataDone;
   assign emitWord = dataDone ?
                     {op_q, addr_q, data_q[`WORD_BITS-2:0], serialInLine} :
                     {hdrFull, 16'h0000};

   // Toggle handshake; the word holds still until acknowledged.
   // A command that arrives while one is still in flight is lost,
   // which only happens if the host ignores the select-high gap.
   always_ff @(posedge serialClockLine or posedge linkRst_q) begin
      if (linkRst_q) begin
         cmdWord_q <= '0;
         reqTgl_q  <= 1'h0;
      end else if (emitNow && selectLine && (reqTgl_q == ackSync)) begin
         cmdWord_q <= emitWord;
         reqTgl_q  <= ~reqTgl_q;
      end
   end

   sync_bits #(.WIDTH(1)) uAckSync (
      .clk  (serialClockLine),
      .rst  (linkRst_q),
      .din  (ackTgl_q),
      .dout (ackSync)
   );

   // ------------------------------------------------------------
   // System clock domain: crossing and buffering
   // ------------------------------------------------------------

   sync_bits #(.WIDTH(2)) uSysSync (
      .clk  (sys_clk),
      .rst  (sys_rst),
      .din  ({selectLine, reqTgl_q}),
      .dout ({csSync, reqSync})
   );

   // Capture a new command word and hold it until the buffer takes it
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reqSeen_q   <= 1'h0;
         ackTgl_q    <= 1'h0;
         pendValid_q <= 1'h0;
         pendWord_q  <= '0;
      end else begin
         if (pendValid_q && fifoInReady) begin
            pendValid_q <= 1'h0;
            ackTgl_q    <= reqSeen_q;
         end else if (!pendValid_q && (reqSync != reqSeen_q)) begin
            pendValid_q <= 1'h1;
            pendWord_q  <= cmdWord_q;
            reqSeen_q   <= reqSync;
         end
      end
   end

   cmd_fifo #(.WIDTH(`CMD_BITS), .DEPTH(FIFO_DEPTH)) uCmdFifo (
      .clk      (sys_clk),
      .rst      (sys_rst),
      .inValid  (pendValid_q),
      .inReady  (fifoInReady),
      .inData   (pendWord_q),
      .outValid (fifoOutValid),
      .outReady (exPop),
      .outData  (fifoOutData)
   );

   // ------------------------------------------------------------
   // System clock domain: programming executor
   // ------------------------------------------------------------

   // Draining stalls while a programming cycle is open
   assign exPop     = (exState_q == EX_IDLE) && fifoOutValid;
   assign popOp     = fifoOutData[`CMD_OP_MSB:`CMD_OP_LSB];
   assign popIsProg = (popOp[3:2] == `OPHI_WRITE) || (popOp[3:2] == `OPHI_ERASE) ||
                      (popOp == `OP_BULK_ERASE) || (popOp == `OP_BULK_WRITE);
   assign progStart = (exState_q == EX_ARM) && !csSync;

   assign exOp   = exWord_q[`CMD_OP_MSB:`CMD_OP_LSB];
   assign exAddr = exWord_q[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
   assign exData = exWord_q[`CMD_DATA_MSB:0];

   // Sequencing: wait for select to fall, program until it rises
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         exState_q <= EX_IDLE;
         exWord_q  <= '0;
      end else begin
         case (exState_q)
            EX_IDLE: begin
               if (exPop && popIsProg && progEnabled) begin
                  exWord_q  <= fifoOutData;
                  exState_q <= EX_ARM;
               end
            end
            EX_ARM: begin
               if (!csSync) begin
                  exState_q <= EX_PROG;
               end
            end
            EX_PROG: begin
               if (csSync) begin
                  exState_q <= EX_IDLE;
               end
            end
            default: begin
               exState_q <= EX_IDLE;
            end
         endcase
      end
   end

   // Programming permission; reads never look at it
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         progEnabled <= `PROG_EN_RESET;
      end else if (exPop && (popOp == `OP_PROG_EN)) begin
         progEnabled <= 1'h1;
      end else if (exPop && (popOp == `OP_PROG_DIS)) begin
         progEnabled <= 1'h0;
      end
   end

   // Generator runs only across the select-low interval
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         progVoltageOn <= 1'h0;
      end else if (progStart) begin
         progVoltageOn <= 1'h1;
      end else if ((exState_q == EX_PROG) && csSync) begin
         progVoltageOn <= 1'h0;
      end
   end

   // Array rows; a cell only changes on the cycle programming opens
   generate
      for (genvar r = 0; r < `ARRAY_WORDS; r++) begin : gRow
         logic hit;
         assign hit = (exAddr == `ADDR_BITS'(r));
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               mem_q[r] <= `ERASED_WORD;
            end else if (progStart) begin
               if (exOp == `OP_BULK_ERASE) begin
                  mem_q[r] <= `ERASED_WORD;
               end else if (exOp == `OP_BULK_WRITE) begin
                  mem_q[r] <= exData;
               end else if (hit && (exOp[3:2] == `OPHI_ERASE)) begin
                  mem_q[r] <= `ERASED_WORD;
               end else if (hit && (exOp[3:2] == `OPHI_WRITE)) begin
                  // Writing only clears bits, so an unerased word merges
                  mem_q[r] <= mem_q[r] & exData;
               end
            end
         end
      end
   endgenerate

endmodule

// ==== serial_eeprom_program_cmds_props.sv ====
`timescale 1ns/1ns
// ----
// Checker on the device pins
// ----
module serial_eeprom_program_cmds_props #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic serialClockLine,
   input wire logic selectLine,
   input wire logic serialInLine,
   input wire logic serialOut,
   input wire logic serialOutEn,
   input wire logic progVoltageOn,
   input wire logic progEnabled
);
   // Generator on and select held low past the synchroniser delay
   sequence pv_low_hold;
      (progVoltageOn && !selectLine) ##1 !selectLine [*3];
   endsequence
   // Read answer: dummy zero, sixteen data edges, then release
   sequence rd_dummy;
      !serialOut && serialOutEn;
   endsequence
   sequence rd_data;
      serialOutEn [*8] ##1 serialOutEn [*8] ##1 !serialOutEn;
   endsequence

   pv_needs_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(progVoltageOn) |-> !$past(selectLine, 1) && !$past(selectLine, 2))
      else $error("generator on without select low");
   sel_high_ends_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(selectLine) |-> ##[1:5] !progVoltageOn)
      else $error("generator still on after select rose");
   prog_holds_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      pv_low_hold |-> progVoltageOn)
      else $error("generator dropped while select low");
   out_only_sel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !selectLine |-> !serialOutEn)
      else $error("serial output driven while deselected");
   read_no_prog_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      serialOutEn |-> !progVoltageOn)
      else $error("generator on during read");
   pv_needs_en_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      progVoltageOn |-> progEnabled)
      else $error("generator on while programming disabled");
   en_stable_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $changed(progEnabled) |-> !progVoltageOn)
      else $error("enable flag changed during programming");
   read_frame_a: assert property (@(posedge serialClockLine) disable iff (sys_rst)
      $rose(serialOutEn) |-> rd_dummy ##1 rd_data)
      else $error("read answer framing wrong");
endmodule

bind serial_eeprom_program_cmds serial_eeprom_program_cmds_props #(
   .FIFO_DEPTH(FIFO_DEPTH)
) u_props (
   .sys_clk(sys_clk),
   .sys_rst(sys_rst),
   .serialClockLine(serialClockLine),
   .selectLine(selectLine),
   .serialInLine(serialInLine),
   .serialOut(serialOut),
   .serialOutEn(serialOutEn),
   .progVoltageOn(progVoltageOn),
   .progEnabled(progEnabled)
);

// ==== sync_bits.sv ====
`timescale 1ns/1ns

// Two-stage synchroniser, one chain per bit
module sync_bits #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : gBit
         logic meta_q;
         // First stage feeds only the second
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               meta_q  <= 1'h0;
               dout[i] <= 1'h0;
            end else begin
               meta_q  <= din[i];
               dout[i] <= meta_q;
            end
         end
      end
   endgenerate

endmodule

// ==== test_serial_eeprom_program_cmds.sv ====
`timescale 1ns/1ns
module test_serial_eeprom_program_cmds;
   logic sys_clk;
   logic sys_rst;
   logic serialClockLine;
   logic selectLine;
   logic serialInLine;
   logic serialOut;
   logic serialOutEn;
   logic progVoltageOn;
   logic progEnabled;
   int   fails    = 0;
   int   n_checks = 0;
   int   pvCycles = 0;

   // ----
   // Clock, generator monitor, instances
   // ----
   initial sys_clk = 1'b0;
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (progVoltageOn === 1'b1) pvCycles++;

   serial_eeprom_program_cmds #(.FIFO_DEPTH(8)) u_serial_eeprom_program_cmds (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .serialClockLine(serialClockLine),
      .selectLine(selectLine),
      .serialInLine(serialInLine),
      .serialOut(serialOut),
      .serialOutEn(serialOutEn),
      .progVoltageOn(progVoltageOn),
      .progEnabled(progEnabled)
   );
   eeprom_host u_eeprom_host (
      .sysClk(sys_clk),
      .serialClockLine(serialClockLine),
      .selectLine(selectLine),
      .serialInLine(serialInLine),
      .serialOut(serialOut),
      .serialOutEn(serialOutEn)
   );

   // ----
   // Compare and report
   // ----
   task automatic chkWord(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic chkBit(input logic got, input logic exp, input string what);
      chkWord({15'h0000, got}, {15'h0000, exp}, what);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Whole read answer judged in one place
   task automatic readCheck(input logic [3:0] op, input logic [3:0] addr, input logic [15:0] exp);
      u_eeprom_host.readWord(op, addr);
      chkBit(u_eeprom_host.rdEnable, 1'b1, "read enable");
      chkBit(u_eeprom_host.rdDummy, 1'b0, "dummy bit");
      chkWord(u_eeprom_host.rdWord, exp, "read word");
      chkBit(u_eeprom_host.rdTail, 1'b0, "released after data");
   endtask
   // Twenty low cycles; generator on for about that many, or for a count outside 15 to 25
   task automatic progCheck(input logic expOn);
      int start;
      start = pvCycles;
      u_eeprom_host.progCycle(20);
      chkBit((pvCycles - start) inside {[15:25]}, expOn, "programming span");
   endtask

   // ----
   // Scenarios
   // ----
   task automatic t_reset_idle;
      chkBit(progEnabled, 1'b0, "enable after reset");
      readCheck(4'h8, 4'h3, 16'hFFFF);
      chkBit(serialOutEn, 1'b0, "output released");
      $display("test reset_idle done");
   endtask
   task automatic t_locked;
      u_eeprom_host.sendCmd(4'h4, 4'h2, 16'h0000, 1'b1);
      progCheck(1'b0);
      readCheck(4'hA, 4'h2, 16'hFFFF);
      $display("test locked done");
   endtask
   task automatic t_enable;
      u_eeprom_host.sendCmd(4'h3, 4'h9, 16'h0000, 1'b0);
      u_eeprom_host.endFrame();
      chkBit(progEnabled, 1'b1, "enable set");
      $display("test enable done");
   endtask
   task automatic t_bulk_write;
      u_eeprom_host.sendCmd(4'h1, 4'h6, 16'h3C5A, 1'b1);
      progCheck(1'b1);
      readCheck(4'h8, 4'h0, 16'h3C5A);
      readCheck(4'hB, 4'hF, 16'h3C5A);
      $display("test bulk_write done");
   endtask
   // Erase then write; a failed erase would leave 3C5A AND A5C3
   task automatic t_word_write;
      u_eeprom_host.sendCmd(4'hD, 4'h5, 16'h0000, 1'b0);
      progCheck(1'b1);
      u_eeprom_host.sendCmd(4'h6, 4'h5, 16'hA5C3, 1'b1);
      progCheck(1'b1);
      readCheck(4'h9, 4'h5, 16'hA5C3);
      readCheck(4'h8, 4'h4, 16'h3C5A);
      $display("test word_write done");
   endtask
   task automatic t_bulk_erase;
      u_eeprom_host.sendCmd(4'h2, 4'hC, 16'h0000, 1'b0);
      progCheck(1'b1);
      readCheck(4'h8, 4'h5, 16'hFFFF);
      readCheck(4'h8, 4'h0, 16'hFFFF);
      $display("test bulk_erase done");
   endtask
   task automatic t_disable;
      u_eeprom_host.sendCmd(4'h0, 4'hF, 16'h0000, 1'b0);
      u_eeprom_host.endFrame();
      chkBit(progEnabled, 1'b0, "enable cleared");
      u_eeprom_host.sendCmd(4'h1, 4'h0, 16'h0000, 1'b1);
      progCheck(1'b0);
      readCheck(4'h8, 4'hB, 16'hFFFF);
      $display("test disable done");
   endtask

   // ----
   // Main sequence and watchdog
   // ----
   initial begin
      sys_rst = 1'b1;
      u_eeprom_host.idleClocks(4);
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      u_eeprom_host.idleClocks(4);
      @(negedge sys_clk);
      t_reset_idle();
      t_locked();
      t_enable();
      t_bulk_write();
      t_word_write();
      t_bulk_erase();
      t_disable();
      conclude();
   end
   // Tests need about 20 us; over ten times that means a hang
   initial begin
      #250000;
      fails++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      conclude();
   end
endmodule
